// ==== sbc_exec.sv ====
// Purpose: Decode and execute return, subtract with borrow and set carry.
// Assumes: Data memory read is combinational on mem_raddr within the cycle.
// Notes: Each decoded word executes in one cycle; results show at the next edge.
`include "sbc_consts.svh"
`default_nettype none
module sbc_exec
  import sbc_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic          instr_valid,
  input  wire logic [15:0]   instr_word,
  input  wire pc_t           stack_top,
  input  wire nibble_t       mem_rdata,
  output maddr_t             mem_raddr,
  output mem_write_s         mem_write,
  output logic               pc_load,
  output pc_t                pc_target,
  output nibble_t            accumulator,
  output logic               carry_flag,
  output logic               zero_flag,
  output logic               decoded
);
  wire logic     is_return;
  wire logic     is_sbc_mem;
  wire logic     is_subtract_with_borrow_writeback_mem;
  wire logic     is_sbc_imm;
  wire logic     is_subtract_with_borrow_writeback_imm;
  wire logic     is_set_carry;
  wire logic     is_imm_form;
  wire logic     is_subtract;
  wire logic     is_writeback;
  wire nibble_t  imm_value;
  wire nibble_t  subtrahend;
  sub_out_s      sub_result;

  assign is_return    = instr_valid && (instr_word == `OP_RETURN);
  assign is_set_carry = instr_valid && (instr_word == `OP_SET_CARRY);
  assign is_sbc_mem   = instr_valid && (instr_word[15:`PFX9_LSB] == `PFX_SBC_MEM);
  assign is_subtract_with_borrow_writeback_mem  = instr_valid && (instr_word[15:`PFX9_LSB] == `PFX_SUBTRACT_WITH_BORROW_WRITEBACK_MEM);
  assign is_sbc_imm   = instr_valid && (instr_word[15:`PFX8_LSB] == `PFX_SBC_IMM);
  assign is_subtract_with_borrow_writeback_imm  = instr_valid && (instr_word[15:`PFX8_LSB] == `PFX_SUBTRACT_WITH_BORROW_WRITEBACK_IMM);
  assign is_imm_form  = is_sbc_imm || is_subtract_with_borrow_writeback_imm;
  assign is_subtract  = is_sbc_mem || is_subtract_with_borrow_writeback_mem || is_imm_form;
  assign is_writeback = is_subtract_with_borrow_writeback_mem || is_subtract_with_borrow_writeback_imm;
  assign imm_value    = instr_word[`IMM_MSB:`IMM_LSB];
  assign decoded      = is_return || is_set_carry || is_subtract;

  // Immediate forms read a working register, memory forms a direct address.
  assign mem_raddr  = is_imm_form ? {`WREG_BASE, instr_word[`WREG_MSB:0]}
                                  : instr_word[`MADDR_MSB:0];
  assign subtrahend = is_imm_form ? imm_value : accumulator; // RULE2 RULE3

  sbc_sub_unit u_sub (
    .minuend    (mem_rdata),
    .subtrahend (subtrahend),
    .borrow_in  (carry_flag),
    .result     (sub_result)
  );

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      accumulator <= `RST_NIBBLE;
      carry_flag  <= 1'b0;
      zero_flag   <= 1'b0;
    end else if (is_subtract) begin
      accumulator <= sub_result.diff; // RULE2 RULE3 RULE4 RULE5
      carry_flag  <= sub_result.borrow; // RULE7
      zero_flag   <= sub_result.zero; // RULE7
    end else if (is_set_carry) begin
      carry_flag  <= 1'b1; // RULE6
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mem_write <= '{we: 1'b0, addr: `RST_MADDR, data: `RST_NIBBLE};
    end else begin
      mem_write.we <= is_writeback; // RULE4 RULE5
      if (is_writeback) begin
        mem_write.addr <= mem_raddr;
        mem_write.data <= sub_result.diff;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pc_load   <= 1'b0;
      pc_target <= `RST_PC;
    end else begin
      pc_load <= is_return; // RULE1
      if (is_return) begin
        pc_target <= stack_top; // RULE1
      end
    end
  end

  wire logic [4:0] check_diff;
  assign check_diff = {1'b0, mem_rdata} - {1'b0, subtrahend} - {4'h0, carry_flag};

  a_return_pc_load: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE1
    is_return |=> pc_load && (pc_target == $past(stack_top)))
    else $error("Return did not load the program counter from the stack.");

  a_no_stray_load: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE1
    !is_return |=> !pc_load)
    else $error("Program counter load without a return.");

  a_sbc_mem_acc: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE2
    is_sbc_mem |=> (accumulator == $past(mem_rdata - accumulator - {3'h0, carry_flag}))
                   && !mem_write.we)
    else $error("Memory subtract gave a wrong accumulator or wrote memory.");

  a_sbc_imm_acc: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE3
    is_sbc_imm |=> (accumulator == $past(mem_rdata - imm_value - {3'h0, carry_flag}))
                   && !mem_write.we)
    else $error("Immediate subtract gave a wrong accumulator.");

  a_subtract_with_borrow_writeback_mem_wb: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE4
    is_subtract_with_borrow_writeback_mem |=> mem_write.we && (mem_write.data == accumulator)
                    && (mem_write.addr == $past(instr_word[`MADDR_MSB:0])))
    else $error("Memory writeback subtract did not store its result.");

  a_subtract_with_borrow_writeback_imm_wb: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE5
    is_subtract_with_borrow_writeback_imm |=> mem_write.we && (mem_write.data == accumulator)
                    && (mem_write.addr == {`WREG_BASE, $past(instr_word[`WREG_MSB:0])}))
    else $error("Register writeback subtract did not store its result.");

  a_set_carry_only: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE6
    is_set_carry |=> carry_flag && $stable(accumulator) && $stable(zero_flag) && !mem_write.we)
    else $error("Set carry changed more than the carry flag.");

  a_sub_flags: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE7
    is_subtract |=> (zero_flag == (accumulator == `RST_NIBBLE))
                    && (carry_flag == $past(check_diff[4])))
    else $error("Subtract flags do not match the result.");

  a_reset_clear: assert property (@(posedge ref_clk)
    !rst_n |=> (accumulator == `RST_NIBBLE) && !carry_flag && !zero_flag)
    else $error("Reset did not clear the accumulator and flags.");

  a_reset_quiet: assert property (@(posedge ref_clk)
    !rst_n |=> !pc_load && !mem_write.we && (pc_target == `RST_PC))
    else $error("Reset left a load or write pending.");

  a_return_acc_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE1
    is_return |=> $stable(accumulator) && $stable(carry_flag) && $stable(zero_flag))
    else $error("Return changed the accumulator or flags.");

  a_return_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE1
    is_return |=> !mem_write.we)
    else $error("Return wrote data memory.");

  a_pc_load_cause: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE1
    pc_load |-> $past(is_return))
    else $error("Program counter load without a preceding return.");

  a_pc_target_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE1
    !is_return |=> $stable(pc_target))
    else $error("Program counter target moved without a return.");

  a_sbc_mem_addr: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE2
    is_sbc_mem |-> (mem_raddr == instr_word[`MADDR_MSB:0]))
    else $error("Memory subtract read the wrong address.");

  a_sbc_mem_pc: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE2
    is_sbc_mem |=> !pc_load)
    else $error("Memory subtract loaded the program counter.");

  a_imm_addr: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE3
    is_imm_form |-> (mem_raddr == {`WREG_BASE, instr_word[`WREG_MSB:0]}))
    else $error("Immediate subtract read the wrong working register.");

  a_sbc_imm_borrow: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE3
    is_sbc_imm |=> carry_flag == $past({1'b0, mem_rdata} < ({1'b0, imm_value} + {4'h0, carry_flag})))
    else $error("Immediate subtract gave a wrong borrow.");

  a_subtract_with_borrow_writeback_mem_acc: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE4
    is_subtract_with_borrow_writeback_mem |=> (accumulator == $past(mem_rdata - accumulator - {3'h0, carry_flag})))
    else $error("Memory writeback subtract gave a wrong accumulator.");

  a_subtract_with_borrow_writeback_mem_addr: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE4
    is_subtract_with_borrow_writeback_mem |-> (mem_raddr == instr_word[`MADDR_MSB:0]))
    else $error("Memory writeback subtract read the wrong address.");

  a_subtract_with_borrow_writeback_imm_acc: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE5
    is_subtract_with_borrow_writeback_imm |=> (accumulator == $past(mem_rdata - imm_value - {3'h0, carry_flag})))
    else $error("Register writeback subtract gave a wrong accumulator.");

  a_wb_cause: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE4
    mem_write.we |-> $past(is_writeback))
    else $error("Memory write without a writeback subtract.");

  a_wb_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE5
    !is_writeback |=> $stable(mem_write.addr) && $stable(mem_write.data))
    else $error("Write address or data moved without a writeback.");

  a_set_carry_pc: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE6
    is_set_carry |=> !pc_load && $stable(pc_target))
    else $error("Set carry touched the program counter.");

  a_sub_borrow: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE7
    is_subtract |=> carry_flag == $past({1'b0, mem_rdata} < ({1'b0, subtrahend} + {4'h0, carry_flag})))
    else $error("Subtract borrow does not match the operands.");

  a_sub_zero: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE7
    is_subtract |=> zero_flag == $past((mem_rdata - subtrahend - {3'h0, carry_flag}) == 4'h0))
    else $error("Subtract zero flag does not match the operands.");

  a_idle_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !decoded |=> $stable(accumulator) && $stable(carry_flag) && $stable(zero_flag))
    else $error("Foreign word changed the accumulator or flags.");

  a_idle_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !decoded |=> !pc_load && !mem_write.we)
    else $error("Foreign word caused a load or a write.");

  a_decode_onehot: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $onehot0({is_return, is_set_carry, is_sbc_mem, is_subtract_with_borrow_writeback_mem, is_sbc_imm, is_subtract_with_borrow_writeback_imm}))
    else $error("More than one instruction decoded at once.");

  a_decode_valid: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !instr_valid |-> !decoded)
    else $error("Decode reported without a valid word.");
endmodule : sbc_exec
`default_nettype wire

// ==== sbc_consts.svh ====
// Purpose: Constants for the subtract, return and set-carry instruction group.
// Assumes: 16-bit program words, 4-bit data, 7-bit data memory address.
// Notes: Working registers sit at data memory addresses 0 to 15.
//
// Contract
// RULE1: Return reloads all eleven program counter bits.
// RULE2: Memory subtract loads accumulator, memory untouched.
// RULE3: Immediate subtract loads accumulator from register.
// RULE4: Memory writeback subtract stores accumulator and memory.
// RULE5: Immediate writeback subtract stores accumulator and register.
// RULE6: Set carry forces carry, touches nothing else.
// RULE7: Zero on zero result; carry is borrow.
`ifndef SBC_CONSTS_SVH
`define SBC_CONSTS_SVH

`define OP_RETURN       16'h0200
`define OP_SET_CARRY    16'h5000
`define PFX_SBC_MEM     9'h014
`define PFX_SUBTRACT_WITH_BORROW_WRITEBACK_MEM    9'h016
`define PFX_SBC_IMM     8'h0e
`define PFX_SUBTRACT_WITH_BORROW_WRITEBACK_IMM    8'h0f
`define PFX9_LSB        7
`define PFX8_LSB        8
`define IMM_MSB         7
`define IMM_LSB         4
`define WREG_MSB        3
`define MADDR_MSB       6
`define WREG_BASE       3'h0
`define RST_NIBBLE      4'h0
`define RST_PC          11'h000
`define RST_MADDR       7'h00

`endif

// ==== sbc_pkg.sv ====
// Purpose: Shared types for the subtract instruction group.
// Assumes: Constants come from sbc_consts.svh.
// Notes: Types only.
`default_nettype none
package sbc_pkg;
  typedef logic [3:0]  nibble_t;
  typedef logic [6:0]  maddr_t;
  typedef logic [10:0] pc_t;

  typedef struct packed {
    nibble_t diff;
    logic    borrow;
    logic    zero;
  } sub_out_s;

  typedef struct packed {
    logic    we;
    maddr_t  addr;
    nibble_t data;
  } mem_write_s;
endpackage : sbc_pkg
`default_nettype wire

// ==== sbc_sub_unit.sv ====
// Purpose: Four-bit subtract with borrow, minuend minus subtrahend minus borrow in.
// Assumes: Pure combinational logic.
// Notes: Borrow out is high when the true difference is negative.
`include "sbc_consts.svh"
`default_nettype none
module sbc_sub_unit
  import sbc_pkg::*;
(
  input  wire nibble_t  minuend,
  input  wire nibble_t  subtrahend,
  input  wire logic     borrow_in,
  output sub_out_s      result
);
  wire logic [4:0] wide_diff;

  assign wide_diff     = {1'b0, minuend} - {1'b0, subtrahend} - {4'h0, borrow_in};
  assign result.diff   = wide_diff[3:0];
  assign result.borrow = wide_diff[4]; // RULE7
  assign result.zero   = (wide_diff[3:0] == `RST_NIBBLE); // RULE7
endmodule : sbc_sub_unit
`default_nettype wire

// ==== tb.sv ====
// Purpose: Self-checking bench for sbc_exec.
// Assumes: Bench serves data memory combinationally and models core state.
// Notes: Each issued word queues a note that is checked on the falling edge after the next rising edge.
`include "sbc_consts.svh"
`default_nettype none
module tb import sbc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    nibble_t a; logic c; logic z; logic p; pc_t t; mem_write_s w; logic d;
  } note_s;
  logic        ref_clk = 0, rst_n = 0, instr_valid = 0, v_d = 0, dec_d = 0;
  logic [15:0] instr_word = 0;
  pc_t         stack_top = 0, pc_target, pt = 0;
  nibble_t     mem_rdata, accumulator, acc = 0;
  maddr_t      mem_raddr;
  mem_write_s  mem_write, lw = 0;
  logic        pc_load, carry_flag, zero_flag, decoded, cf = 0, zf = 0;
  nibble_t     mem [128];
  nibble_t     em [128];
  note_s       q[$];
  note_s       n;
  int          bad_count = 0, num_checks = 0, cyc = 0;
  assign mem_rdata = mem[mem_raddr];
  sbc_exec dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .stack_top(stack_top), .mem_rdata(mem_rdata),
    .mem_raddr(mem_raddr), .mem_write(mem_write), .pc_load(pc_load),
    .pc_target(pc_target), .accumulator(accumulator), .carry_flag(carry_flag),
    .zero_flag(zero_flag), .decoded(decoded));
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  // Memory takes the registered write in the same step, so back-to-back reads see it.
  always @(mem_write) begin
    if (mem_write.we) mem[mem_write.addr] = mem_write.data;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  always @(posedge ref_clk) begin
    cyc++;
    v_d <= instr_valid && rst_n;
    dec_d <= decoded;
    if (cyc == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic chk(input note_s e);
    note_s g;
    g = {accumulator, carry_flag, zero_flag, pc_load, pc_target, mem_write, dec_d};
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  always @(negedge ref_clk) begin
    if (v_d) begin
      n = q.pop_front();
      chk(n);
    end
  end
  task automatic issue(input int k);
    logic [31:0] r;
    logic [15:0] w;
    logic [4:0]  d;
    logic        im, rm, wb;
    maddr_t      ad;
    pc_t         s;
    r = $urandom;
    s = r[30:20];
    case (k)
      0: w = `OP_RETURN;
      1: w = `OP_SET_CARRY;
      2: w = {`PFX_SBC_MEM, r[6:0]};
      3: w = {`PFX_SUBTRACT_WITH_BORROW_WRITEBACK_MEM, r[6:0]};
      4: w = {`PFX_SBC_IMM, r[7:0]};
      5: w = {`PFX_SUBTRACT_WITH_BORROW_WRITEBACK_IMM, r[7:0]};
      default: w = {9'h074, r[6:0]};
    endcase
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr_word  <= w;
    stack_top   <= s;
    im = w[15:8] == `PFX_SBC_IMM || w[15:8] == `PFX_SUBTRACT_WITH_BORROW_WRITEBACK_IMM;
    rm = w[15:7] == `PFX_SBC_MEM || w[15:7] == `PFX_SUBTRACT_WITH_BORROW_WRITEBACK_MEM;
    wb = w[15:7] == `PFX_SUBTRACT_WITH_BORROW_WRITEBACK_MEM || w[15:8] == `PFX_SUBTRACT_WITH_BORROW_WRITEBACK_IMM;
    ad = im ? {3'h0, w[3:0]} : w[6:0];
    lw.we = 1'b0;
    if (k == 0) pt = s;
    if (k == 1) cf = 1'b1;
    if (im || rm) begin
      d = {1'b0, em[ad]} - {1'b0, im ? w[7:4] : acc} - {4'h0, cf};
      acc = d[3:0];
      cf = d[4];
      zf = d[3:0] == 4'h0;
      if (wb) begin
        em[ad] = d[3:0];
        lw = {1'b1, ad, d[3:0]};
      end
    end
    q.push_back({acc, cf, zf, k == 0, pt, lw, (k < 2) || im || rm});
  endtask : issue
  initial begin
    void'($urandom(32'h13d5808e));
    foreach (mem[i]) begin
      mem[i] = nibble_t'($urandom);
      em[i] = mem[i];
    end
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk('0);
    for (int k = 0; k < 7; k++) issue(k);
    $display("test directed done");
    for (int i = 0; i < 600; i++) issue($urandom % 7);
    $display("test random done");
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
